// *** shared/rsc_regs.vh ***
// rsc_regs.vh: offsets, field positions, reset values and counts of the
// reset source combiner.
// assumes: included by bare name from the design files, before any module.
//
// What this block does
// - any active reset source drives system reset
// - control bits reset at power-on only; cause flags keep own rules
// - each reset type sets its own cause flag
// - power-on clears flags, power-on flag stays set
// - software may write every implemented bit; same-cycle hardware events win
// - software flag writes never assert system reset
// - trap conflict reset sets bit 15
// - illegal opcode or bad pointer sets bit 14
// - bits 13 to 10 read zero, ignore writes
// - configuration mismatch reset sets bit 9
// - bit 8 keeps regulator active in sleep
// - master clear pin reset sets bit 7
// - reset instruction sets bit 6
// - bit 5 or fuse enables the watchdog
// - watchdog expiry sets bit 4
// - sleep sets bit 3, idle sets bit 2
// - brown-out sets bit 1, power-up bit 0
// - clearing events per flag as tabled
`ifndef RSC_REGS_VH
`define RSC_REGS_VH

// register word addresses
`define RSC_OFS_CAUSE 4'h0
`define RSC_OFS_LIVE 4'h1
`define RSC_OFS_COUNT 4'h2

// reset cause status field positions
`define RSC_BIT_TRAP 15
`define RSC_BIT_ILLOP 14
`define RSC_BIT_CFGMM 9
`define RSC_BIT_VREG 8
`define RSC_BIT_EXTPIN 7
`define RSC_BIT_SWRST 6
`define RSC_BIT_WDTEN 5
`define RSC_BIT_WATCHDOG_TIMEOUT_FLAG 4
`define RSC_BIT_SLEEP 3
`define RSC_BIT_IDLE 2
`define RSC_BIT_BOR 1
`define RSC_BIT_POR 0

// implemented bits, power-on value, bits that survive a brown-out
`define RSC_CAUSE_MASK 16'hC3FF
`define RSC_CAUSE_POR 16'h0001
`define RSC_BOR_KEEP 16'h01A1

// live source register field positions
`define RSC_LIVE_SYSTEM_RESET_OUT 8
`define RSC_LIVE_WDTRUN 9

// cycles that system reset stays high after the last source drops
`define RSC_HOLD_CYC 8'h10

`endif

// *** design/rsc_sync.v ***
// rsc_sync.v: two-flop synchroniser for a group of pin levels.
// assumes: inputs are asynchronous levels; rst is synchronous, active high.
`timescale 1ns/1ps
module rsc_sync #(
   parameter WIDTH = 2,
   parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
   input wire clk, // system clock
   input wire rst, // synchronous reset, active high
   input wire [WIDTH-1:0] async_in, // raw pin levels
   output wire [WIDTH-1:0] sync_out // levels in clk domain
);
   reg [WIDTH-1:0] meta_q;
   reg [WIDTH-1:0] sync_q;

   always @(posedge clk) begin
      if (rst) begin
         meta_q <= INIT;
         sync_q <= INIT;
      end else begin
         meta_q <= async_in;
         sync_q <= meta_q;
      end
   end

   assign sync_out = sync_q;
endmodule // rsc_sync

// *** design/rsc_top.v ***
// rsc_top.v: reset source combiner with reset cause status register.
// assumes: rst is the power-on reset, synchronous to clk at 25 MHz;
// brown-out and master clear arrive as raw pin levels; all other
// sources are same-clock pulses from the core and watchdog.
//
// The register offsets and strobed register access were chosen for this implementation.
`timescale 1ns/1ps
`include "rsc_regs.vh"
module rsc_top #(
   parameter [7:0] HOLD_CYC = `RSC_HOLD_CYC
) (
   input wire clk, // system clock, 25 MHz
   input wire rst, // power-on reset, sync, active high
   input wire [3:0] reg_addr, // register word address
   input wire [15:0] reg_wdata, // register write data
   input wire reg_wr, // write strobe
   input wire reg_rd, // read strobe
   output reg [15:0] reg_rdata, // read data, cycle after strobe
   input wire brownout_reset, // brown-out detector pin, active high
   input wire master_clear_pin_n, // master clear pin, active low
   input wire reset_instr, // reset instruction executed, pulse
   input wire watchdog_timeout, // watchdog expired, pulse
   input wire trap_conflict, // trap conflict, pulse
   input wire illegal_op, // illegal opcode or pointer, pulse
   input wire config_mismatch, // configuration mismatch, pulse
   input wire watchdog_clear_instr, // watchdog clear instruction, pulse
   input wire power_save_instr, // power save instruction, pulse
   input wire power_save_idle, // with power save: 1 idle, 0 sleep
   input wire watchdog_fuse_enable, // watchdog fuse config bit
   output reg system_reset_out, // system reset, active high
   output reg watchdog_enable, // watchdog timer runs
   output reg regulator_sleep_keep // regulator stays active in sleep
);
   // synchronised pin levels
   wire [1:0] pin_sync;
   wire bor_lvl;
   wire master_clear_pin_lvl;

   // register state
   reg [15:0] cause_q;
   reg [15:0] cause_d;
   reg [7:0] hold_q;
   reg [7:0] hold_d;
   reg [7:0] count_q;
   reg [7:0] count_d;

   // decoded accesses
   wire wr_cause;
   wire wr_count;
   wire [15:0] live_word;
   reg [15:0] rd_mux;

   // source collection
   wire [7:0] src_vec;
   wire any_src;
   wire new_episode;

   rsc_sync #(
      .WIDTH(2),
      .INIT(2'b10)
   ) u_pin_sync (
      .clk(clk),
      .rst(rst),
      .async_in({master_clear_pin_n, brownout_reset}),
      .sync_out(pin_sync)
   );

   assign bor_lvl = pin_sync[0];
   assign master_clear_pin_lvl = ~pin_sync[1];

   // every source that forces system reset
   assign src_vec = {config_mismatch,
                     illegal_op,
                     trap_conflict,
                     watchdog_timeout,
                     reset_instr,
                     master_clear_pin_lvl,
                     bor_lvl,
                     1'b0};

   // software writes are not sources, so never reach reset
   assign any_src = |src_vec;
   assign new_episode = any_src & ~system_reset_out;

   assign wr_cause = reg_wr & (reg_addr == `RSC_OFS_CAUSE);
   assign wr_count = reg_wr & (reg_addr == `RSC_OFS_COUNT);

   // live view of sources and outputs
   assign live_word = {6'h00,
                       watchdog_enable,
                       system_reset_out,
                       src_vec};

   // cause register next state
   always @* begin
      cause_d = cause_q;
      // software writes every implemented bit, either value
      if (wr_cause) begin
         cause_d = reg_wdata & `RSC_CAUSE_MASK;
      end
      // watchdog flag cleared by power save or watchdog clear
      if (watchdog_clear_instr | power_save_instr) begin
         cause_d[`RSC_BIT_WATCHDOG_TIMEOUT_FLAG] = 1'b0;
      end
      // brown-out clears all but pin flag, power-on flag, controls
      if (bor_lvl) begin
         cause_d = cause_d & `RSC_BOR_KEEP;
      end
      // hardware sets come last so they win over writes
      if (trap_conflict) begin
         cause_d[`RSC_BIT_TRAP] = 1'b1;
      end
      if (illegal_op) begin
         cause_d[`RSC_BIT_ILLOP] = 1'b1;
      end
      if (config_mismatch) begin
         cause_d[`RSC_BIT_CFGMM] = 1'b1;
      end
      if (master_clear_pin_lvl) begin
         cause_d[`RSC_BIT_EXTPIN] = 1'b1;
      end
      if (reset_instr) begin
         cause_d[`RSC_BIT_SWRST] = 1'b1;
      end
      if (watchdog_timeout) begin
         cause_d[`RSC_BIT_WATCHDOG_TIMEOUT_FLAG] = 1'b1;
      end
      if (power_save_instr & ~power_save_idle) begin
         cause_d[`RSC_BIT_SLEEP] = 1'b1;
      end
      if (power_save_instr & power_save_idle) begin
         cause_d[`RSC_BIT_IDLE] = 1'b1;
      end
      if (bor_lvl) begin
         cause_d[`RSC_BIT_BOR] = 1'b1;
      end
   end

   // stretch of system reset after the last source drops
   always @* begin
      hold_d = hold_q;
      if (any_src) begin
         hold_d = HOLD_CYC;
      end else if (hold_q != 8'h00) begin
         hold_d = hold_q - 8'h01;
      end
   end

   // count of reset episodes, saturating, cleared by a write
   always @* begin
      count_d = count_q;
      if (wr_count) begin
         count_d = 8'h00;
      end
      if (new_episode && count_q != 8'hFF) begin
         count_d = count_q + 8'h01;
      end
   end

   // read multiplexer, unmapped addresses read zero
   always @* begin
      case (reg_addr)
         `RSC_OFS_CAUSE: rd_mux = cause_q & `RSC_CAUSE_MASK;
         `RSC_OFS_LIVE: rd_mux = live_word;
         `RSC_OFS_COUNT: rd_mux = {8'h00, count_q};
         default: rd_mux = 16'h0000;
      endcase
   end

   // power-on leaves only the power-on flag set
   always @(posedge clk) begin
      if (rst) begin
         cause_q <= `RSC_CAUSE_POR;
         hold_q <= HOLD_CYC;
         count_q <= 8'h00;
      end else begin
         cause_q <= cause_d;
         hold_q <= hold_d;
         count_q <= count_d;
      end
   end

   // read data stands only in the cycle after the strobe
   always @(posedge clk) begin
      if (rst) begin
         reg_rdata <= 16'h0000;
      end else if (reg_rd) begin
         reg_rdata <= rd_mux;
      end else begin
         reg_rdata <= 16'h0000;
      end
   end

   // outputs straight from flops
   always @(posedge clk) begin
      if (rst) begin
         system_reset_out <= 1'b1;
         watchdog_enable <= 1'b0;
         regulator_sleep_keep <= 1'b0;
      end else begin
         system_reset_out <= any_src | (hold_d != 8'h00);
         watchdog_enable <= watchdog_fuse_enable |
                            cause_d[`RSC_BIT_WDTEN];
         regulator_sleep_keep <= cause_d[`RSC_BIT_VREG];
      end
   end
endmodule // rsc_top

// *** testbench/rsc_props_properties.sv ***
// rsc_props_properties.sv: port assertions for the reset combiner.
// assumes: bound to rsc_top; one clock, synchronous reset rst.
`timescale 1ns/1ps
module rsc_props #(
   parameter [7:0] HOLD_CYC = 8'h10
) (
   input wire clk, // clock
   input wire rst, // reset
   input wire [3:0] reg_addr, // address
   input wire [15:0] reg_wdata, // wdata
   input wire reg_wr, // write
   input wire reg_rd, // read
   input wire [15:0] reg_rdata, // rdata
   input wire brownout_reset, // pin
   input wire master_clear_pin_n, // pin
   input wire reset_instr, // src
   input wire watchdog_timeout, // src
   input wire trap_conflict, // src
   input wire illegal_op, // src
   input wire config_mismatch, // src
   input wire watchdog_clear_instr, // clear
   input wire power_save_instr, // clear
   input wire watchdog_fuse_enable, // fuse
   input wire system_reset_out, // out
   input wire watchdog_enable, // out
   input wire regulator_sleep_keep // out
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   wire pin = brownout_reset | ~master_clear_pin_n;
   wire src = reset_instr | watchdog_timeout | trap_conflict | illegal_op |
      config_mismatch;
   reg [2:0] pin_q;
   // pin history covers the synchroniser delay
   always @(posedge clk) pin_q <= {pin_q[1:0], pin};
   wire quiet = ~|pin_q & ~pin & ~src & ~watchdog_clear_instr &
      ~power_save_instr;
   wire wr0 = reg_wr & (reg_addr == 4'h0);
   wire rd0 = reg_rd & (reg_addr == 4'h0);
   property p_src; src |=> system_reset_out; endproperty
   a_src: assert property (p_src) else $error("source no reset");
   property p_pin; pin [*3] |-> ##1 system_reset_out; endproperty
   a_pin: assert property (p_pin) else $error("pin no reset");
   property p_sw; quiet && !system_reset_out |=> !system_reset_out; endproperty
   a_sw: assert property (p_sw) else $error("spurious reset");
   property p_gap; rd0 |=> reg_rdata[13:10] == 4'h0; endproperty
   a_gap: assert property (p_gap) else $error("gap bits set");
   property p_wr; wr0 && quiet ##1 rd0 && quiet |=>
      reg_rdata == ($past(reg_wdata, 2) & 16'hC3FF); endproperty
   a_wr: assert property (p_wr) else $error("write lost");
   property p_vreg; wr0 |=> regulator_sleep_keep == $past(reg_wdata[8]);
   endproperty
   a_vreg: assert property (p_vreg) else $error("regulator bit");
   property p_fuse; watchdog_fuse_enable |=> watchdog_enable; endproperty
   a_fuse: assert property (p_fuse) else $error("fuse ignored");
   property p_wds; wr0 && !watchdog_fuse_enable |=>
      watchdog_enable == $past(reg_wdata[5]); endproperty
   a_wds: assert property (p_wds) else $error("soft enable");
endmodule // rsc_props
bind rsc_top rsc_props #(.HOLD_CYC(HOLD_CYC)) rsc_props_i (.*);

// *** testbench/rsc_src_model.sv ***
// rsc_src_model.sv: core, watchdog and trap logic as reset sources.
// assumes: fire and sel change just after a rising clk edge.
`timescale 1ns/1ps
module rsc_src_model (
   input wire clk, // system clock
   input wire fire, // request one pulse
   input wire [2:0] sel, // which source
   output reg reset_instr, // sel 0
   output reg watchdog_timeout, // sel 1
   output reg trap_conflict, // sel 2
   output reg illegal_op, // sel 3
   output reg config_mismatch, // sel 4
   output reg watchdog_clear_instr, // sel 5
   output reg power_save_instr // sel 6
);
   // one-cycle pulse per request
   always @(posedge clk) {power_save_instr, watchdog_clear_instr,
      config_mismatch, illegal_op, trap_conflict, watchdog_timeout,
      reset_instr} <= fire ? (7'h01 << sel) : 7'h00;
endmodule // rsc_src_model

// *** testbench/tb.sv ***
// tb.sv: self-checking bench for the reset source combiner.
// assumes: rsc_top with HOLD_CYC 2; core sources from rsc_src_model.
`timescale 1ns/1ps
module tb;
   reg clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, fire = 1'b0;
   reg brownout_reset = 1'b0, master_clear_pin_n = 1'b1;
   reg power_save_idle = 1'b0, watchdog_fuse_enable = 1'b0;
   reg [3:0] reg_addr = 4'h0;
   reg [2:0] sel = 3'h0;
   reg [15:0] reg_wdata = 16'h0000, r;
   wire [15:0] reg_rdata;
   wire reset_instr, watchdog_timeout, trap_conflict, illegal_op;
   wire config_mismatch, watchdog_clear_instr, power_save_instr;
   wire system_reset_out, watchdog_enable, regulator_sleep_keep;
   integer n_errors = 0, n_tests = 0, cyc = 0, i, j;
   rsc_src_model rsc_src_model_i (.*);
   rsc_top #(.HOLD_CYC(8'h02)) rsc_top_i (.*);
   initial forever #20 clk = ~clk;
   task print_verdict;
      $display("tests %0d errors %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc = cyc + 1;
      if (cyc == 5000) begin
         n_errors = n_errors + 1;
         print_verdict;
      end
   end
   task chk(input [15:0] got, input [15:0] exp);
      n_tests = n_tests + 1;
      if (got !== exp) begin
         n_errors = n_errors + 1;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // tasks start just after a rising edge; a write may be followed
   // directly by a read, so the write lands in the cycle before it
   task wr(input [3:0] a, input [15:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task rd(input [3:0] a, input [15:0] e);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(negedge clk);
      chk(reg_rdata, e);
      @(posedge clk);
   endtask
   task src(input [2:0] k);
      fire <= 1'b1;
      sel <= k;
      @(posedge clk);
      fire <= 1'b0;
   endtask
   task settle;
      repeat (4) @(posedge clk);
      i = 0;
      while (system_reset_out !== 1'b0 && i < 64) begin
         @(posedge clk);
         i = i + 1;
      end
      chk({15'h0000, system_reset_out}, 16'h0000);
   endtask
   function [15:0] flag(input [2:0] k);
      case (k)
         3'd0: flag = 16'h0040;
         3'd1: flag = 16'h0010;
         3'd2: flag = 16'h8000;
         3'd3: flag = 16'h4000;
         default: flag = 16'h0200;
      endcase
   endfunction
   function [15:0] keep(input [15:0] v);
      keep = (v & 16'h01A1) | 16'h0002;
   endfunction
   initial begin
      r = $urandom(83173);
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      rd(4'h0, 16'h0001);
      rd(4'hF, 16'h0000);
      for (j = 0; j < 5; j = j + 1) begin
         wr(4'h0, 16'h0000);
         src(j[2:0]);
         settle;
         rd(4'h0, flag(j[2:0]));
      end
      wr(4'h0, 16'h0000);
      master_clear_pin_n <= 1'b0;
      repeat (4) @(posedge clk);
      master_clear_pin_n <= 1'b1;
      settle;
      rd(4'h0, 16'h0080);
      for (j = 0; j < 3; j = j + 1) begin
         power_save_idle <= j[0];
         wr(4'h0, 16'h0010);
         src(j == 2 ? 3'd5 : 3'd6);
         repeat (2) @(posedge clk);
         rd(4'h0, j == 2 ? 16'h0000 : (j[0] ? 16'h0004 : 16'h0008));
      end
      for (j = 0; j < 8; j = j + 1) begin
         r = $urandom;
         wr(4'h0, r);
         rd(4'h0, r & 16'hC3FF);
      end
      chk({watchdog_enable, regulator_sleep_keep}, {r[5], r[8]});
      brownout_reset <= 1'b1;
      repeat (4) @(posedge clk);
      brownout_reset <= 1'b0;
      settle;
      rd(4'h0, keep(r));
      watchdog_fuse_enable <= 1'b1;
      wr(4'h0, 16'h0000);
      @(negedge clk);
      chk({15'h0000, watchdog_enable}, 16'h0001);
      @(posedge clk);
      src(3'd2);
      reg_wdata <= 16'h0000;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      settle;
      rd(4'h0, 16'h8000);
      rd(4'h1, 16'h0200);
      rd(4'h2, 16'h0008);
      wr(4'h2, 16'h0000);
      rd(4'h2, 16'h0000);
      print_verdict;
   end
endmodule // tb
